// >>> hdl/sdpa_pkg.sv
// constants, states and carrier types of the dual-port sdram arbiter
// assumes one system clock domain shared by both request ports
package sdpa_pkg;

  localparam int unsigned ADDR_W = 26;  // 64 Mbyte reach
  localparam int unsigned LEN_W  = 5;

  // burst lengths in beats
  localparam logic [LEN_W-1:0] VID_BURST_LEN = 5'h10;
  localparam logic [LEN_W-1:0] SYS_BURST_LEN = 5'h08;

  // handover address field and its boundary code
  localparam int unsigned       QUAD_LSB  = 2;
  localparam logic [1:0]        QUAD_LAST = 2'h3;

  // device density codes
  localparam logic [1:0] DENS_16M  = 2'h0;
  localparam logic [1:0] DENS_64M  = 2'h1;
  localparam logic [1:0] DENS_128M = 2'h2;
  localparam logic [1:0] DENS_256M = 2'h3;

  // lowest byte-address bit of the chip index per density
  localparam int unsigned CHIP_SHIFT_16M  = 21;
  localparam int unsigned CHIP_SHIFT_64M  = 23;
  localparam int unsigned CHIP_SHIFT_128M = 24;
  localparam int unsigned CHIP_SHIFT_256M = 25;

  // reset values
  localparam logic [LEN_W-1:0] BEAT_RST = 5'h00;

  typedef enum logic [2:0] {
    SDPA_IDLE = 3'b001,
    SDPA_VID  = 3'b010,
    SDPA_SYS  = 3'b100
  } sdpa_state_t;

  typedef struct packed {
    logic              from_video;
    logic              write;
    logic [1:0]        chip;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
  } sdpa_cmd_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
  } sdpa_sys_req_t;

endpackage

// >>> hdl/sdpa_arbiter.sv
// arbiter front end of a two-port sdram controller: system bus mastership,
// video/system sdram access selection, two-entry command buffer
// assumes a burst sequencer downstream that strobes one pulse per data beat
// Operation
// - bus handover only idle or quad boundary
// - video beats system for sdram
// - video bursts are exactly 16 half-words
// - video burst uses first address only
// - system sdram bursts are eight half-words
// - one to four x16 devices, four densities
// - video burst never stalls system bus
`timescale 1ns/1ns
module sdpa_arbiter
#(
  parameter int unsigned NUM_MASTERS = 2
)
(
  input  wire logic                       SYS_CLK_IN,      // system clock
  input  wire logic                       RESET_N_IN,      // async reset
  input  wire logic [NUM_MASTERS-1:0]     BUS_REQ_IN,      // master requests
  input  wire logic                       BUS_BUSY_IN,     // transfer active
  input  wire logic [1:0]                 BUS_ADDR_IN,     // address bits 3:2
  output logic      [NUM_MASTERS-1:0]     BUS_GRANT_OUT,   // one-hot grant
  input  wire logic                       VID_REQ_IN,      // video burst req
  input  wire logic [sdpa_pkg::ADDR_W-1:0] VID_ADDR_IN,    // video address
  output logic                            VID_ACK_OUT,     // video taken
  input  wire logic                       SYS_SD_REQ_IN,   // sdram req pulse
  input  wire sdpa_pkg::sdpa_sys_req_t    SYS_SD_IN,       // sdram req data
  output logic                            SYS_SD_PEND_OUT, // request waiting
  output logic                            SYS_SD_ACK_OUT,  // request issued
  input  wire logic [1:0]                 CFG_DEVICES_IN,  // devices minus 1
  input  wire logic [1:0]                 CFG_DENSITY_IN,  // density code
  output logic                            RANGE_ERR_OUT,   // beyond devices
  output logic                            CMD_VALID_OUT,   // command valid
  output sdpa_pkg::sdpa_cmd_t             CMD_OUT,         // command word
  input  wire logic                       CMD_READY_IN,    // sequencer ready
  input  wire logic                       BEAT_IN,         // one data beat
  output logic                            VID_ACTIVE_OUT,  // video burst on
  output logic                            SYS_ACTIVE_OUT   // system burst on
);

  // elaboration guard on the master count
  if (NUM_MASTERS < 1 || NUM_MASTERS > 8)
  begin : g_bad_masters
    $error("NUM_MASTERS must be 1 to 8");
  end

  // lowest-index requester wins; master 0 parks the bus
  function automatic logic [NUM_MASTERS-1:0] pick_master
  (
    input logic [NUM_MASTERS-1:0] req
  );
    logic [NUM_MASTERS-1:0] g;
    g = '0;
    for (int i = NUM_MASTERS - 1; i >= 0; i--)
    begin
      if (req[i])
        g = '0;
      if (req[i])
        g[i] = 1'b1;
    end
    if (req == '0)
      g[0] = 1'b1;
    return g;
  endfunction

  // chip index from address and density
  function automatic logic [2:0] chip_of
  (
    input logic [sdpa_pkg::ADDR_W-1:0] a,
    input logic [1:0]                  dens
  );
    logic [sdpa_pkg::ADDR_W-1:0] s;
    s = '0;
    unique case (dens)
      sdpa_pkg::DENS_16M:  s = a >> sdpa_pkg::CHIP_SHIFT_16M;
      sdpa_pkg::DENS_64M:  s = a >> sdpa_pkg::CHIP_SHIFT_64M;
      sdpa_pkg::DENS_128M: s = a >> sdpa_pkg::CHIP_SHIFT_128M;
      sdpa_pkg::DENS_256M: s = a >> sdpa_pkg::CHIP_SHIFT_256M;
    endcase
    return (s > 3) ? 3'h4 : s[2:0];
  endfunction

  sdpa_pkg::sdpa_state_t           state_q;
  logic [sdpa_pkg::LEN_W-1:0]      beat_q;
  logic                            pend_q;
  sdpa_pkg::sdpa_sys_req_t         pend_req_q;
  sdpa_pkg::sdpa_cmd_t             tail_q;
  logic                            tail_v_q;
  logic                            full;
  logic                            issue_vid;
  logic                            issue_sys;
  logic                            push;
  logic                            pop;
  logic                            burst_end;
  logic [sdpa_pkg::LEN_W-1:0]      cur_len;
  sdpa_pkg::sdpa_cmd_t             push_cmd;
  logic [2:0]                      push_chip;

  // system bus mastership, independent of sdram traffic
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
      BUS_GRANT_OUT <= NUM_MASTERS'(1);
    else if (!BUS_BUSY_IN ||
             BUS_ADDR_IN == sdpa_pkg::QUAD_LAST)
      BUS_GRANT_OUT <= pick_master(BUS_REQ_IN);
  end

  assign full      = CMD_VALID_OUT && tail_v_q;
  assign issue_vid = (state_q == sdpa_pkg::SDPA_IDLE) && !full
                     && VID_REQ_IN;
  assign issue_sys = (state_q == sdpa_pkg::SDPA_IDLE) && !full
                     && !VID_REQ_IN && pend_q;
  assign push      = issue_vid || issue_sys;
  assign pop       = CMD_VALID_OUT && CMD_READY_IN;

  // command built from the first video address only
  always_comb
  begin
    push_cmd = '0;
    if (issue_vid)
    begin
      push_cmd.from_video = 1'b1;
      push_cmd.addr       = VID_ADDR_IN;
      push_cmd.len        = sdpa_pkg::VID_BURST_LEN;
    end
    else
    begin
      push_cmd.write = pend_req_q.write;
      push_cmd.addr  = pend_req_q.addr;
      push_cmd.len   = sdpa_pkg::SYS_BURST_LEN;
    end
    push_chip     = chip_of(push_cmd.addr, CFG_DENSITY_IN);
    push_cmd.chip = push_chip[1:0];
  end

  // pending system request; a new one in the issue cycle is kept
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      pend_q     <= 1'b0;
      pend_req_q <= '0;
    end
    else if (SYS_SD_REQ_IN && (!pend_q || issue_sys))
    begin
      pend_q     <= 1'b1;
      pend_req_q <= SYS_SD_IN;
    end
    else if (issue_sys)
      pend_q <= 1'b0;
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      VID_ACK_OUT     <= 1'b0;
      SYS_SD_ACK_OUT  <= 1'b0;
      SYS_SD_PEND_OUT <= 1'b0;
      RANGE_ERR_OUT   <= 1'b0;
    end
    else
    begin
      VID_ACK_OUT     <= issue_vid;
      SYS_SD_ACK_OUT  <= issue_sys;
      SYS_SD_PEND_OUT <= (pend_q && !issue_sys) || SYS_SD_REQ_IN;
      RANGE_ERR_OUT   <= push &&
                         (push_chip > {1'b0, CFG_DEVICES_IN});
    end
  end

  // burst tracking: counts sequencer beats to the fixed length
  assign cur_len   = (state_q == sdpa_pkg::SDPA_VID) ?
                     sdpa_pkg::VID_BURST_LEN : sdpa_pkg::SYS_BURST_LEN;
  assign burst_end = BEAT_IN && (beat_q == cur_len - 5'h01);

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      state_q <= sdpa_pkg::SDPA_IDLE;
      beat_q  <= sdpa_pkg::BEAT_RST;
    end
    else
    begin
      unique case (state_q)
        sdpa_pkg::SDPA_IDLE:
        begin
          beat_q <= sdpa_pkg::BEAT_RST;
          if (issue_vid)
            state_q <= sdpa_pkg::SDPA_VID;
          else if (issue_sys)
            state_q <= sdpa_pkg::SDPA_SYS;
        end
        sdpa_pkg::SDPA_VID,
        sdpa_pkg::SDPA_SYS:
        begin
          if (burst_end)
          begin
            state_q <= sdpa_pkg::SDPA_IDLE;
            beat_q  <= sdpa_pkg::BEAT_RST;
          end
          else if (BEAT_IN)
            beat_q <= beat_q + 5'h01;
        end
        default:
        begin
          state_q <= sdpa_pkg::SDPA_IDLE;
          beat_q  <= sdpa_pkg::BEAT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      VID_ACTIVE_OUT <= 1'b0;
      SYS_ACTIVE_OUT <= 1'b0;
    end
    else
    begin
      VID_ACTIVE_OUT <= issue_vid ||
                        (state_q == sdpa_pkg::SDPA_VID && !burst_end);
      SYS_ACTIVE_OUT <= issue_sys ||
                        (state_q == sdpa_pkg::SDPA_SYS && !burst_end);
    end
  end

  // two-entry command buffer; head register drives the outputs
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      CMD_VALID_OUT <= 1'b0;
      CMD_OUT       <= '0;
      tail_v_q      <= 1'b0;
      tail_q        <= '0;
    end
    else if (pop)
    begin
      CMD_VALID_OUT <= tail_v_q || push;
      CMD_OUT       <= tail_v_q ? tail_q : push_cmd;
      tail_v_q      <= tail_v_q && push;
      if (tail_v_q && push)
        tail_q <= push_cmd;
    end
    else if (push)
    begin
      if (!CMD_VALID_OUT)
      begin
        CMD_VALID_OUT <= 1'b1;
        CMD_OUT       <= push_cmd;
      end
      else
      begin
        tail_v_q <= 1'b1;
        tail_q   <= push_cmd;
      end
    end
  end

endmodule

// >>> bench/sdpa_checker.sv
// assertion checker for the dual-port sdram arbiter
// bound onto sdpa_arbiter; sees only its ports
`timescale 1ns/1ns
module sdpa_checker
#(
  parameter int unsigned NUM_MASTERS = 2
)
(
  input wire logic                    SYS_CLK_IN,      // clock
  input wire logic                    RESET_N_IN,      // async reset
  input wire logic [NUM_MASTERS-1:0]  BUS_REQ_IN,      // requests
  input wire logic                    BUS_BUSY_IN,     // transfer on
  input wire logic [1:0]              BUS_ADDR_IN,     // bits 3:2
  input wire logic [NUM_MASTERS-1:0]  BUS_GRANT_OUT,   // grant
  input wire logic                    VID_REQ_IN,      // video req
  input wire logic [25:0]             VID_ADDR_IN,     // video addr
  input wire logic                    VID_ACK_OUT,     // video taken
  input wire logic                    SYS_SD_PEND_OUT, // sys waiting
  input wire logic                    SYS_SD_ACK_OUT,  // sys issued
  input wire logic [1:0]              CFG_DEVICES_IN,  // devices - 1
  input wire logic                    RANGE_ERR_OUT,   // bad chip
  input wire logic                    CMD_VALID_OUT,   // cmd valid
  input wire sdpa_pkg::sdpa_cmd_t     CMD_OUT,         // cmd word
  input wire logic                    BEAT_IN,         // data beat
  input wire logic                    VID_ACTIVE_OUT,  // video open
  input wire logic                    SYS_ACTIVE_OUT   // sys open
);
  logic [NUM_MASTERS-1:0] win;
  logic [4:0]             beats_q;
  assign win = BUS_REQ_IN & (~BUS_REQ_IN + 1'b1);
  // video beats since the last take
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      beats_q <= 5'h00;
    else if (VID_ACK_OUT)
      beats_q <= 5'h00;
    else if (VID_ACTIVE_OUT && BEAT_IN)
      beats_q <= beats_q + 5'h01;
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  AST_GRANT_HOLD: assert property (
    $changed(BUS_GRANT_OUT) |->
    $past(BUS_BUSY_IN) == 1'b0 || $past(BUS_ADDR_IN) == 2'h3)
    else $error("grant moved inside a quad");
  AST_GRANT_PICK: assert property (
    !BUS_BUSY_IN || BUS_ADDR_IN == 2'h3 |=> BUS_GRANT_OUT ==
    (|$past(BUS_REQ_IN) ? $past(win) : NUM_MASTERS'(1)))
    else $error("wrong grant");
  AST_VID_FIRST: assert property (
    SYS_SD_ACK_OUT |-> !$past(VID_REQ_IN) ||
    $past(VID_ACTIVE_OUT) || $past(SYS_ACTIVE_OUT))
    else $error("system issued over video");
  AST_VID_LEN: assert property (
    CMD_VALID_OUT && CMD_OUT.from_video |-> CMD_OUT.len == 5'h10)
    else $error("video length wrong");
  AST_VID_BEATS: assert property (
    $fell(VID_ACTIVE_OUT) |-> beats_q == 5'h10)
    else $error("video burst beat count wrong");
  AST_VID_ADDR: assert property (
    VID_ACK_OUT && $rose(CMD_VALID_OUT) |->
    CMD_OUT.addr == $past(VID_ADDR_IN))
    else $error("video address not the first");
  AST_SYS_LEN: assert property (
    CMD_VALID_OUT && !CMD_OUT.from_video |-> CMD_OUT.len == 5'h08)
    else $error("system length wrong");
  AST_RANGE: assert property (
    $rose(CMD_VALID_OUT) |->
    RANGE_ERR_OUT == (CMD_OUT.chip > CFG_DEVICES_IN))
    else $error("range flag wrong");
  AST_SYS_SERVED: assert property (
    $rose(SYS_SD_PEND_OUT) |-> ##[1:600] SYS_SD_ACK_OUT)
    else $error("pending system request lost");
endmodule

// >>> bench/sdpa_seq_model.sv
// burst sequencer stand-in: takes commands, gives one beat a cycle
// sits on the command side of sdpa_arbiter; stall comes from bench
`timescale 1ns/1ns
module sdpa_seq_model
(
  input  wire logic                SYS_CLK_IN,    // clock
  input  wire logic                RESET_N_IN,    // async reset
  input  wire logic                CMD_VALID_OUT, // command offered
  input  wire sdpa_pkg::sdpa_cmd_t CMD_OUT,       // command word
  input  wire logic                stall_in,      // hold off taking
  output logic                     CMD_READY_IN,  // command taken
  output logic                     BEAT_IN        // data beat
);
  logic [4:0] left_q;
  assign CMD_READY_IN = left_q == 5'h00 && !stall_in;
  assign BEAT_IN = left_q != 5'h00;
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN)
    if (!RESET_N_IN)
      left_q <= 5'h00;
    else if (CMD_VALID_OUT && CMD_READY_IN)
      left_q <= CMD_OUT.len;
    else if (BEAT_IN)
      left_q <= left_q - 5'h01;
endmodule

// >>> bench/test_sdpa_arbiter.sv
// self-checking bench for the dual-port sdram arbiter
// needs sdpa_pkg, sdpa_arbiter, sdpa_checker, sdpa_seq_model
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
`define WT(c) begin n = 0; while (!(c) && n < 900) begin \
  @(negedge SYS_CLK_IN); n++; end if (n == 900) begin failures++; \
  end_sim(); end end
module test_sdpa_arbiter;
  logic SYS_CLK_IN = 0, RESET_N_IN = 0, BUS_BUSY_IN = 0, VID_REQ_IN = 0;
  logic SYS_SD_REQ_IN = 0, CMD_READY_IN, BEAT_IN, stall = 0, w;
  logic [1:0] BUS_REQ_IN = 0, BUS_ADDR_IN = 0, CFG_DEVICES_IN = 0;
  logic [1:0] CFG_DENSITY_IN = 0, BUS_GRANT_OUT;
  logic [25:0] VID_ADDR_IN = 0, va, sa;
  logic VID_ACK_OUT, SYS_SD_PEND_OUT, SYS_SD_ACK_OUT, RANGE_ERR_OUT;
  logic CMD_VALID_OUT, VID_ACTIVE_OUT, SYS_ACTIVE_OUT;
  sdpa_pkg::sdpa_sys_req_t SYS_SD_IN = '0;
  sdpa_pkg::sdpa_cmd_t CMD_OUT, got, exp_q[$];
  int failures = 0, checks = 0, n, s;
  logic [31:0] x = 32'h6a41;
  sdpa_arbiter #(.NUM_MASTERS(2)) dut_u
  (
    .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
    .BUS_REQ_IN(BUS_REQ_IN), .BUS_BUSY_IN(BUS_BUSY_IN),
    .BUS_ADDR_IN(BUS_ADDR_IN), .BUS_GRANT_OUT(BUS_GRANT_OUT),
    .VID_REQ_IN(VID_REQ_IN), .VID_ADDR_IN(VID_ADDR_IN),
    .VID_ACK_OUT(VID_ACK_OUT), .SYS_SD_REQ_IN(SYS_SD_REQ_IN),
    .SYS_SD_IN(SYS_SD_IN), .SYS_SD_PEND_OUT(SYS_SD_PEND_OUT),
    .SYS_SD_ACK_OUT(SYS_SD_ACK_OUT), .CFG_DEVICES_IN(CFG_DEVICES_IN),
    .CFG_DENSITY_IN(CFG_DENSITY_IN), .RANGE_ERR_OUT(RANGE_ERR_OUT),
    .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT),
    .CMD_READY_IN(CMD_READY_IN), .BEAT_IN(BEAT_IN),
    .VID_ACTIVE_OUT(VID_ACTIVE_OUT), .SYS_ACTIVE_OUT(SYS_ACTIVE_OUT)
  );
  sdpa_seq_model seq_u
  (
    .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
    .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT), .stall_in(stall),
    .CMD_READY_IN(CMD_READY_IN), .BEAT_IN(BEAT_IN)
  );
  always #5 SYS_CLK_IN = ~SYS_CLK_IN;
  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic sdpa_pkg::sdpa_cmd_t mk(logic v, logic wr,
                                             logic [25:0] a);
    return '{v, wr, 2'(a >> s), a, v ? 5'h10 : 5'h08};
  endfunction
  task end_sim();
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bus traffic and sequencer stalls run free
  always @(negedge SYS_CLK_IN)
    {BUS_REQ_IN, BUS_ADDR_IN, BUS_BUSY_IN, stall} = 6'(rnd());
  always @(posedge SYS_CLK_IN)
    if (RESET_N_IN && CMD_VALID_OUT && CMD_READY_IN)
    begin
      `CHK(exp_q.size() != 0, 1'b1)
      got = exp_q.size() != 0 ? exp_q.pop_front() : '0;
      `CHK(CMD_OUT, got)
    end
  initial
  begin
    repeat (10) @(negedge SYS_CLK_IN);
    `CHK({BUS_GRANT_OUT, CMD_VALID_OUT}, 3'b010)
    RESET_N_IN = 1;
    for (int i = 0; i < 16; i++)
    begin
      CFG_DENSITY_IN = i[1:0];
      CFG_DEVICES_IN = 2'(rnd());
      s = i % 4 == 0 ? sdpa_pkg::CHIP_SHIFT_16M : i % 4 == 1 ?
          sdpa_pkg::CHIP_SHIFT_64M : i % 4 == 2 ?
          sdpa_pkg::CHIP_SHIFT_128M : sdpa_pkg::CHIP_SHIFT_256M;
      va = 26'(rnd()) >> (s < 24 ? 24 - s : 0);
      sa = 26'(rnd()) >> (s < 24 ? 24 - s : 0);
      w = 1'(rnd());
      VID_REQ_IN = 1;
      VID_ADDR_IN = va;
      SYS_SD_REQ_IN = 1;
      SYS_SD_IN = '{w, sa};
      exp_q.push_back(mk(1'b1, 1'b0, va));
      exp_q.push_back(mk(1'b0, w, sa));
      @(negedge SYS_CLK_IN);
      `WT(VID_ACK_OUT)
      `CHK(SYS_SD_PEND_OUT, 1'b1)
      `CHK(RANGE_ERR_OUT, (va >> s) > CFG_DEVICES_IN)
      // later address and a second request must both be ignored
      VID_REQ_IN = 0;
      VID_ADDR_IN = ~va;
      SYS_SD_IN = ~SYS_SD_IN;
      @(negedge SYS_CLK_IN);
      SYS_SD_REQ_IN = 0;
      // held system request issued once the video burst is done
      `WT(SYS_SD_ACK_OUT)
      `CHK(SYS_SD_PEND_OUT, 1'b0)
      `CHK(RANGE_ERR_OUT, (sa >> s) > CFG_DEVICES_IN)
      `WT(!VID_ACTIVE_OUT && !SYS_ACTIVE_OUT && exp_q.size() == 0)
    end
    `CHK(exp_q.size(), 0)
    end_sim();
  end
endmodule
bind sdpa_arbiter sdpa_checker #(.NUM_MASTERS(NUM_MASTERS)) chk_u
(
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_N_IN(RESET_N_IN),
  .BUS_REQ_IN(BUS_REQ_IN), .BUS_BUSY_IN(BUS_BUSY_IN),
  .BUS_ADDR_IN(BUS_ADDR_IN), .BUS_GRANT_OUT(BUS_GRANT_OUT),
  .VID_REQ_IN(VID_REQ_IN), .VID_ADDR_IN(VID_ADDR_IN),
  .VID_ACK_OUT(VID_ACK_OUT), .SYS_SD_PEND_OUT(SYS_SD_PEND_OUT),
  .SYS_SD_ACK_OUT(SYS_SD_ACK_OUT), .CFG_DEVICES_IN(CFG_DEVICES_IN),
  .RANGE_ERR_OUT(RANGE_ERR_OUT), .CMD_VALID_OUT(CMD_VALID_OUT),
  .CMD_OUT(CMD_OUT), .BEAT_IN(BEAT_IN),
  .VID_ACTIVE_OUT(VID_ACTIVE_OUT), .SYS_ACTIVE_OUT(SYS_ACTIVE_OUT)
);
